// File: rtl/asu_uart.v
// Asynchronous serial unit with AHB-Lite register slave
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "asu_consts.vh"
`default_nettype none
module asu_uart (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire rx_pin,
    output reg tx_out,
    output reg tx_oe,
    output reg rx_in_sel,
    output reg pullup_off,
    output reg irq
);
// ****************************************
// Bus front end
// ****************************************
reg ap_wr;
reg ap_rd;
reg [7:0] ap_addr;
wire ap_take = hsel && hready && htrans[1];
// Register the address phase; every access is zero wait state
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ap_wr <= 1'b0;
        ap_rd <= 1'b0;
        ap_addr <= 8'h00;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end else begin
        ap_wr <= ap_take && hwrite;
        ap_rd <= ap_take && !hwrite;
        ap_addr <= haddr;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end
end
// ****************************************
// Registers and flags
// ****************************************
reg [7:0] frame;
reg [7:0] enirq;
reg [7:0] baud;
reg parity_error_flag, noise, framing_error_flag, ovr, receiver_idle_flag, transmitter_idle_flag, tempty;
reg [8:0] fifo0, fifo1;
reg [2:0] err0, err1; // parity, noise, framing per entry
reg [1:0] fcnt;
reg [7:0] txd;
reg tx8;
reg st_rd_seen; // Status read armed the clear sequence
reg sync1, sync2, rx_d;
wire en = frame[`ASU_FC_EN];
wire transmitter_enable = en && enirq[`ASU_EC_TRANSMITTER_ENABLE];
wire receiver_enable = en && enirq[`ASU_EC_RECEIVER_ENABLE];
wire rfull = (fcnt != 2'b00);
wire data_wr = ap_wr && ap_addr == `ASU_OFF_DATA;
wire data_rd = ap_rd && ap_addr == `ASU_OFF_DATA;
wire stat_rd = ap_rd && ap_addr == `ASU_OFF_STATUS;
wire [7:0] status = {parity_error_flag, noise, framing_error_flag, ovr, receiver_idle_flag, rfull, transmitter_idle_flag, tempty};
// Receive line synchroniser
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        sync1 <= 1'b1;
        sync2 <= 1'b1;
        rx_d <= 1'b1;
    end else begin
        sync1 <= rx_pin;
        sync2 <= sync1;
        rx_d <= sync2;
    end
end
// ****************************************
// Baud tick generator
// ****************************************
reg [7:0] bcnt;
reg tick; // One tick per sample, OSR samples per bit
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        bcnt <= 8'h00;
        tick <= 1'b0;
    end else if (!en) begin
        bcnt <= 8'h00;
        tick <= 1'b0;
    end else if (bcnt >= baud) begin
        bcnt <= 8'h00;
        tick <= 1'b1;
    end else begin
        bcnt <= bcnt + 8'h01;
        tick <= 1'b0;
    end
end
wire [7:0] osr = enirq[`ASU_EC_HS] ? `ASU_OSR_HI : `ASU_OSR_LO;
// Frame length in bits after start: data and parity, stop bits not counted
function [3:0] asu_len;
    input nine;
    input pen;
    begin
        asu_len = (nine ? 4'd9 : 4'd8) + {3'b000, pen};
    end
endfunction
wire [3:0] dlen = asu_len(frame[`ASU_FC_NINE], frame[`ASU_FC_PEN]);
// ****************************************
// Transmitter
// ****************************************
localparam TX_IDLE = 2'd0;
localparam TX_SHIFT = 2'd1;
localparam TX_BRK = 2'd2;
reg [1:0] tx_st;
reg [10:0] tsr;
reg [3:0] tbits;
reg [7:0] tsmp;
reg tx_pend;
wire txpar = ^{txd, tx8 & frame[`ASU_FC_NINE]} ^ frame[`ASU_FC_ODD];
wire [9:0] tword = frame[`ASU_FC_NINE] ? {1'b1, txpar, tx8, txd[7:1]} :
    {2'b11, txpar, txd[7:1]};
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        tx_st <= TX_IDLE;
        tsr <= 11'h7FF;
        tbits <= 4'h0;
        tsmp <= 8'h00;
        tx_pend <= 1'b0;
        tempty <= 1'b1;
        transmitter_idle_flag <= 1'b1;
        tx_out <= 1'b1;
        txd <= 8'h00;
        tx8 <= 1'b0;
    end else if (!transmitter_enable) begin
        tx_st <= TX_IDLE;
        tx_pend <= 1'b0;
        tempty <= 1'b1;
        transmitter_idle_flag <= 1'b1;
        tx_out <= 1'b1;
    end else begin
        if (data_wr) begin
            txd <= hwdata[7:0];
            tx8 <= frame[`ASU_FC_TX8];
            tx_pend <= 1'b1;
            if (st_rd_seen) begin
                tempty <= 1'b0;
                transmitter_idle_flag <= 1'b0;
            end
        end
        case (tx_st)
        TX_IDLE: begin
            tx_out <= 1'b1;
            if (tx_pend && !data_wr) begin
                // Start bit first, then data LSB first
                tsr <= frame[`ASU_FC_PEN] ? {tword, txd[0]} :
                    {1'b1, frame[`ASU_FC_NINE] ? {1'b1, tx8} : 2'b11, txd};
                tx_out <= 1'b0;
                tbits <= dlen + (frame[`ASU_FC_TWO] ? 4'd2 : 4'd1);
                tsmp <= 8'h00;
                tx_pend <= 1'b0;
                tempty <= 1'b1;
                tx_st <= TX_SHIFT;
            end else if (frame[`ASU_FC_BRK]) begin
                tx_out <= 1'b0;
                tbits <= `ASU_BREAK_BITS;
                tsmp <= 8'h00;
                tx_st <= TX_BRK;
            end else if (tempty && !tx_pend && !data_wr) begin // A write queues data
                transmitter_idle_flag <= 1'b1;
            end
        end
        TX_SHIFT: if (tick) begin
            if (tsmp == osr - 8'h01) begin
                tsmp <= 8'h00;
                if (tbits == 4'h0) begin
                    tx_st <= TX_IDLE;
                end else begin
                    tx_out <= tsr[0];
                    tsr <= {1'b1, tsr[10:1]};
                    tbits <= tbits - 4'h1;
                end
            end else begin
                tsmp <= tsmp + 8'h01;
            end
        end
        TX_BRK: if (tick) begin
            if (tsmp == osr - 8'h01) begin
                tsmp <= 8'h00;
                if (tbits != 4'h0) begin
                    tbits <= tbits - 4'h1;
                end else if (!frame[`ASU_FC_BRK]) begin
                    tx_st <= TX_IDLE;
                end
            end else begin
                tsmp <= tsmp + 8'h01;
            end
        end
        default: tx_st <= TX_IDLE;
        endcase
    end
end
// ****************************************
// Receiver
// ****************************************
localparam RX_IDLE = 2'd0;
localparam RX_BITS = 2'd1;
localparam RX_STOP = 2'd2;
reg [1:0] rx_st;
reg [9:0] rsr;
reg [3:0] rbits;
reg [7:0] rsmp;
reg [2:0] votes; // Three samples around bit centre
reg rnoise;
reg rdone;
reg [2:0] rerr;
reg [8:0] rword;
wire vote = (votes[0] & votes[1]) | (votes[1] & votes[2]) | (votes[0] & votes[2]);
wire vnoise = !(votes == 3'b000 || votes == 3'b111);
wire [7:0] half = {1'b0, osr[7:1]};
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        rx_st <= RX_IDLE;
        rsr <= 10'h000;
        rbits <= 4'h0;
        rsmp <= 8'h00;
        votes <= 3'b111;
        rnoise <= 1'b0;
        rdone <= 1'b0;
        rerr <= 3'b000;
        rword <= 9'h000;
        receiver_idle_flag <= 1'b1;
    end else if (!receiver_enable) begin
        rx_st <= RX_IDLE;
        rdone <= 1'b0;
        receiver_idle_flag <= 1'b1;
    end else begin
        rdone <= 1'b0;
        if (tick) begin
            votes <= {votes[1:0], rx_d};
        end
        case (rx_st)
        RX_IDLE: begin
            receiver_idle_flag <= 1'b1;
            if (!rx_d && tick) begin
                rx_st <= RX_BITS; // Low start bit seen
                receiver_idle_flag <= 1'b0;
                rsmp <= 8'h00;
                rbits <= dlen;
                rnoise <= 1'b0;
            end
        end
        RX_BITS: if (tick) begin
            if (rsmp == osr - 8'h01) begin
                rsmp <= 8'h00;
            end else begin
                rsmp <= rsmp + 8'h01;
            end
            if (rsmp == half + 8'h01) begin
                rnoise <= rnoise | vnoise;
                if (rbits == dlen && vote) begin
                    rx_st <= RX_IDLE; // False start
                end else if (rbits == 4'h0) begin
                    rx_st <= RX_STOP;
                end
                if (rbits != dlen) begin
                    rsr <= {vote, rsr[9:1]};
                end
                if (rbits != 4'h0) begin
                    rbits <= rbits - 4'h1;
                end
            end
        end
        RX_STOP: if (tick) begin
            // Wait for the stop bit centre, then align, check parity and stop
            if (rsmp == osr - 8'h01) begin
                rsmp <= 8'h00;
            end else begin
                rsmp <= rsmp + 8'h01;
            end
            if (rsmp == half + 8'h01) begin
                rx_st <= RX_IDLE;
                rdone <= 1'b1;
                case ({frame[`ASU_FC_NINE], frame[`ASU_FC_PEN]})
                2'b00: rword <= {1'b0, rsr[9:2]};
                2'b01: rword <= {1'b0, rsr[8:1]};
                2'b10: rword <= rsr[9:1];
                default: rword <= rsr[8:0];
                endcase
                rerr <= {frame[`ASU_FC_PEN] &&
                    ((frame[`ASU_FC_NINE] ? ^rsr : ^rsr[9:1]) ^ frame[`ASU_FC_ODD]),
                    rnoise | vnoise, !vote};
            end
        end
        default: rx_st <= RX_IDLE;
        endcase
    end
end
// ****************************************
// Receive buffer and error flags
// ****************************************
wire pop = data_rd && st_rd_seen && rfull;
// Sequence flag: status read arms, data access consumes
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        st_rd_seen <= 1'b0;
    end else if (stat_rd) begin
        st_rd_seen <= 1'b1;
    end else if (data_rd || data_wr) begin
        st_rd_seen <= 1'b0;
    end
end
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        fcnt <= 2'b00;
        fifo0 <= 9'h000;
        fifo1 <= 9'h000;
        err0 <= 3'b000;
        err1 <= 3'b000;
        parity_error_flag <= 1'b0;
        noise <= 1'b0;
        framing_error_flag <= 1'b0;
        ovr <= 1'b0;
    end else if (!en) begin
        fcnt <= 2'b00;
        parity_error_flag <= 1'b0;
        noise <= 1'b0;
        framing_error_flag <= 1'b0;
        ovr <= 1'b0;
    end else begin
        // Clear by sequence; a new event below wins
        if (st_rd_seen && (data_rd || data_wr)) begin
            parity_error_flag <= 1'b0;
            noise <= 1'b0;
            framing_error_flag <= 1'b0;
            ovr <= 1'b0;
        end
        if (pop) begin
            fifo0 <= fifo1;
            err0 <= err1;
        end
        if (rdone && (ovr || (fcnt == 2'b10 && !pop))) begin
            ovr <= 1'b1;
            fcnt <= fcnt - {1'b0, pop};
        end else if (rdone) begin
            // Two-entry buffer
            if (fcnt == 2'b00 || (fcnt == 2'b01 && pop)) begin
                fifo0 <= rword;
                err0 <= rerr;
            end else begin
                fifo1 <= rword;
                err1 <= rerr;
            end
            fcnt <= fcnt + 2'b01 - {1'b0, pop};
            parity_error_flag <= rerr[2];
            noise <= rerr[1];
            framing_error_flag <= rerr[0];
        end else if (pop) begin
            fcnt <= fcnt - 2'b01;
        end
    end
end
// ****************************************
// Software registers and read mux
// ****************************************
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        frame <= `ASU_RST_FRAME;
        enirq <= `ASU_RST_ENIRQ;
        baud <= `ASU_RST_BAUD;
    end else begin
        if (ap_wr && ap_addr == `ASU_OFF_FRAME) begin
            frame <= {hwdata[7:2], 1'b0, hwdata[0]};
        end else if (!en) begin
            frame[`ASU_FC_BRK] <= 1'b0;
        end
        if (ap_wr && ap_addr == `ASU_OFF_ENIRQ) begin
            enirq <= hwdata[7:0];
        end else if (!en) begin
            enirq[`ASU_EC_TRANSMITTER_ENABLE] <= 1'b0;
            enirq[`ASU_EC_RECEIVER_ENABLE] <= 1'b0;
        end
        if (ap_wr && ap_addr == `ASU_OFF_BAUD) begin
            baud <= hwdata[7:0];
        end
    end
end
// Read data is captured as the read address phase is taken, so it stands
// through the data phase straight from a flop and is zero otherwise
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hrdata <= 32'h00000000;
    end else if (ap_take && !hwrite) begin
        case (haddr)
        `ASU_OFF_STATUS: hrdata <= {24'h000000, status};
        `ASU_OFF_FRAME: hrdata <= {24'h000000, frame[7:2], fifo0[8], 1'b0};
        `ASU_OFF_ENIRQ: hrdata <= {24'h000000, enirq};
        `ASU_OFF_DATA: hrdata <= {24'h000000, fifo0[7:0]};
        `ASU_OFF_BAUD: hrdata <= {24'h000000, baud};
        default: hrdata <= 32'h00000000;
        endcase
    end else begin
        hrdata <= 32'h00000000;
    end
end
// ****************************************
// Pins and interrupt
// ****************************************
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        tx_oe <= 1'b0;
        rx_in_sel <= 1'b0;
        pullup_off <= 1'b0;
        irq <= 1'b0;
    end else begin
        tx_oe <= transmitter_enable;
        rx_in_sel <= receiver_enable;
        pullup_off <= transmitter_enable || receiver_enable;
        irq <= (enirq[`ASU_EC_RIE] && (rfull || ovr)) ||
            (enirq[`ASU_EC_TX_IDLE_IRQ_ENABLE] && transmitter_enable && transmitter_idle_flag) ||
            (enirq[`ASU_EC_TX_EMPTY_IRQ_ENABLE] && transmitter_enable && tempty) ||
            (enirq[`ASU_EC_ADDR] && rfull && fifo0[8]) ||
            (enirq[`ASU_EC_WAKE] && receiver_enable && !rx_d);
    end
end
endmodule // asu_uart
`default_nettype wire

// File: rtl/asu_consts.vh
// Constants of the asynchronous serial unit: offsets, fields, resets, timing
`ifndef ASU_CONSTS_VH
`define ASU_CONSTS_VH
// Register byte offsets
`define ASU_OFF_STATUS 8'h00
`define ASU_OFF_FRAME 8'h04
`define ASU_OFF_ENIRQ 8'h08
`define ASU_OFF_DATA 8'h0C
`define ASU_OFF_BAUD 8'h10
// Status field positions
`define ASU_ST_PARITY_ERROR_FLAG 7
`define ASU_ST_NOISE 6
`define ASU_ST_FRAMING_ERROR_FLAG 5
`define ASU_ST_OVR 4
`define ASU_ST_RECEIVER_IDLE_FLAG 3
`define ASU_ST_RFULL 2
`define ASU_ST_TRANSMITTER_IDLE_FLAG 1
`define ASU_ST_TEMPTY 0
// Frame control field positions
`define ASU_FC_EN 7
`define ASU_FC_NINE 6
`define ASU_FC_PEN 5
`define ASU_FC_ODD 4
`define ASU_FC_TWO 3
`define ASU_FC_BRK 2
`define ASU_FC_RX8 1
`define ASU_FC_TX8 0
// Enable and interrupt control field positions
`define ASU_EC_TRANSMITTER_ENABLE 7
`define ASU_EC_RECEIVER_ENABLE 6
`define ASU_EC_HS 5
`define ASU_EC_ADDR 4
`define ASU_EC_WAKE 3
`define ASU_EC_RIE 2
`define ASU_EC_TX_IDLE_IRQ_ENABLE 1
`define ASU_EC_TX_EMPTY_IRQ_ENABLE 0
// Reset values
`define ASU_RST_FRAME 8'h00
`define ASU_RST_ENIRQ 8'h00
`define ASU_RST_BAUD 8'h00
// Samples per bit: low speed and high speed
`define ASU_OSR_LO 8'h40
`define ASU_OSR_HI 8'h10
// Break bit periods counted after the first low one; a break lasts at least 14 bit periods
`define ASU_BREAK_BITS 4'hD
`endif

// File: tb/asu_uart_properties.sv
// Concurrent checks on the serial unit's bus and pin ports
`timescale 1ns/1ps
`default_nettype none
module asu_uart_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic tx_out,
    input wire logic tx_oe,
    input wire logic rx_in_sel,
    input wire logic pullup_off
);
    // ****************************************************************
    // Taken address phases
    // ****************************************************************
    wire wr_take = hsel && hready && htrans[1] && hwrite;
    wire rd_take = hsel && hready && htrans[1] && !hwrite;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Slave never stalls and never errors
    chk_ready_high: assert property (hreadyout)
        else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    // Owned pins have their pull-up switched off
    chk_oe_pullup: assert property (tx_oe |-> pullup_off)
        else $error("tx pin owned with pull-up on");
    chk_rxsel_pullup: assert property (rx_in_sel |-> pullup_off)
        else $error("rx pin owned with pull-up on");
    // Any low level on the line lasts at least one shortest bit
    chk_start_len: assert property ($fell(tx_out) && tx_oe |->
        !tx_out[*8] ##1 !tx_out[*8])
        else $error("low level on tx shorter than a bit");
    // Read data only in the data phase of a read
    chk_hrdata_idle: assert property (!$past(rd_take) |-> hrdata == 32'h0)
        else $error("hrdata not zero outside read data phase");
    chk_upper_zero: assert property (hrdata[31:8] == 24'h0)
        else $error("hrdata upper bits not zero");
    // Transmit pin ownership only moves after a register write
    chk_oe_by_write: assert property ($changed(tx_oe) |->
        $past(wr_take, 2) || $past(wr_take, 3) || $past(wr_take, 4))
        else $error("tx_oe changed without a write");
    // Released transmitter rests high
    chk_tx_rest_high: assert property (!tx_oe && !$past(tx_oe) &&
        !$past(tx_oe, 2) |-> tx_out)
        else $error("tx_out low while released");
endmodule // asu_uart_props

bind asu_uart asu_uart_props chk (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .tx_out(tx_out),
    .tx_oe(tx_oe),
    .rx_in_sel(rx_in_sel),
    .pullup_off(pullup_off)
);
`default_nettype wire

// File: tb/asu_far_end.sv
// Remote serial device on the far side of the transmit and receive lines
`timescale 1ns/1ps
`default_nettype none
module asu_far_end #(
    parameter int BIT = 32
) (
    input wire logic hclk,
    input wire logic tx_line,
    output logic rx_line
);
    // ****************************************************************
    // Line driver and line sampler
    // ****************************************************************
    initial rx_line = 1'b1;

    // Sends one parity framed character with the unit's own settings
    task automatic send(input logic [7:0] d, input logic odd,
                        input logic bad_par, input logic bad_stop);
        logic [9:0] f;
        f = {(^d) ^ odd ^ bad_par, d, 1'b0};
        @(posedge hclk);
        for (int i = 0; i < 10; i++) begin
            rx_line <= f[i];
            repeat (BIT) @(posedge hclk);
        end
        rx_line <= ~bad_stop;
        // A broken stop is cut short so it cannot pass for a new start
        repeat (bad_stop ? BIT * 3 / 4 : BIT) @(posedge hclk);
        rx_line <= 1'b1;
        repeat (BIT) @(posedge hclk);
    endtask

    // Samples one character at bit centres, LSB first
    task automatic grab(input int nstop, output logic [7:0] d, output logic ok);
        @(negedge tx_line);
        repeat (BIT / 2) @(posedge hclk);
        ok = !tx_line;
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge hclk);
            d[i] = tx_line;
        end
        for (int i = 0; i < nstop; i++) begin
            repeat (BIT) @(posedge hclk);
            ok = ok & tx_line;
        end
    endtask
endmodule // asu_far_end
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench of the serial unit with a remote serial device
`timescale 1ns/1ps
`include "asu_consts.vh"
`default_nettype none
module testbench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    logic [7:0] got;
    logic ok;
    wire [31:0] hrdata;
    wire hreadyout, hresp, tx_out, tx_oe, rx_in_sel, pullup_off, irq, rx_line;
    int n_fail = 0;
    int tests_run = 0;

    always #10 hclk = ~hclk;

    asu_uart uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .rx_pin(rx_line), .tx_out(tx_out), .tx_oe(tx_oe), .rx_in_sel(rx_in_sel),
        .pullup_off(pullup_off), .irq(irq));
    asu_far_end #(.BIT(32)) peer (.hclk(hclk), .tx_line(tx_out), .rx_line(rx_line));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One single AHB-Lite transfer; read data lands in rd
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic settle();
        repeat (3) @(posedge hclk);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        xfer(0, `ASU_OFF_STATUS, 0);
        check("status reset", rd, 32'h0B);
        xfer(0, `ASU_OFF_FRAME, 0);
        check("frame reset", rd, 32'h00);
        xfer(1, `ASU_OFF_STATUS, 32'hFF);
        xfer(0, `ASU_OFF_STATUS, 0);
        check("status read only", rd, 32'h0B);
        xfer(1, 8'h14, 32'h5A);
        xfer(0, 8'h14, 0);
        check("unmapped", rd, 32'h0);
        check("tx released", {tx_oe, pullup_off}, 32'h0);
    endtask

    task automatic t_enable();
        xfer(1, `ASU_OFF_BAUD, 32'h01);
        xfer(0, `ASU_OFF_BAUD, 0);
        check("baud", rd, 32'h01);
        xfer(1, `ASU_OFF_FRAME, 32'h88);
        xfer(1, `ASU_OFF_ENIRQ, 32'h60);
        settle();
        check("rx only pins", {tx_oe, rx_in_sel, pullup_off}, 32'h3);
        xfer(1, `ASU_OFF_ENIRQ, 32'hE1);
        settle();
        check("tx empty irq", irq, 32'h1);
        xfer(1, `ASU_OFF_ENIRQ, 32'hE4);
        settle();
        check("tx owned", {tx_oe, pullup_off}, 32'h3);
    endtask

    task automatic t_transmit();
        xfer(0, `ASU_OFF_STATUS, 0);
        check("tx flags idle", rd & 32'h03, 32'h03);
        fork
            peer.grab(2, got, ok);
            begin
                xfer(1, `ASU_OFF_DATA, 32'hA5);
                xfer(0, `ASU_OFF_STATUS, 0);
                check("tx busy", rd & 32'h02, 32'h00);
            end
        join
        check("tx data", got, 32'hA5);
        check("tx framing", ok, 32'h1);
        // The sampler two_stop_select at mid stop bit; let the last stop bit end
        repeat (64) @(posedge hclk);
        xfer(0, `ASU_OFF_STATUS, 0);
        check("tx idle again", rd & 32'h03, 32'h03);
    endtask

    task automatic t_receive();
        xfer(1, `ASU_OFF_FRAME, 32'hB0);
        peer.send(8'h3C, 1, 0, 0);
        xfer(0, `ASU_OFF_STATUS, 0);
        check("rx good", rd & 32'hE4, 32'h04);
        check("rx irq", irq, 32'h1);
        xfer(0, `ASU_OFF_DATA, 0);
        check("rx data", rd, 32'h3C);
        xfer(0, `ASU_OFF_STATUS, 0);
        check("rx empty", rd & 32'h04, 32'h0);
        check("rx irq off", irq, 32'h0);
        peer.send(8'h5A, 1, 1, 0);
        xfer(0, `ASU_OFF_STATUS, 0);
        check("parity err", rd & 32'hA4, 32'h84);
        xfer(0, `ASU_OFF_DATA, 0);
        xfer(0, `ASU_OFF_STATUS, 0);
        check("parity clr", rd & 32'hE4, 32'h0);
        peer.send(8'h11, 1, 0, 1);
        xfer(0, `ASU_OFF_STATUS, 0);
        check("frame err", rd & 32'hA4, 32'h24);
        xfer(0, `ASU_OFF_DATA, 0);
        xfer(0, `ASU_OFF_STATUS, 0);
        check("frame clr", rd & 32'hE4, 32'h0);
    endtask

    task automatic t_overrun();
        for (int i = 1; i < 4; i++)
            peer.send(i[7:0], 1, 0, 0);
        xfer(0, `ASU_OFF_STATUS, 0);
        check("overrun", rd & 32'h14, 32'h14);
        xfer(0, `ASU_OFF_DATA, 0);
        check("fifo head", rd, 32'h01);
        xfer(0, `ASU_OFF_STATUS, 0);
        check("overrun clr", rd & 32'h14, 32'h04);
        xfer(0, `ASU_OFF_DATA, 0);
        check("fifo second", rd, 32'h02);
        xfer(0, `ASU_OFF_STATUS, 0);
        check("fifo empty", rd & 32'h04, 32'h0);
    endtask

    task automatic t_disable();
        peer.send(8'h77, 1, 0, 0);
        xfer(1, `ASU_OFF_FRAME, 32'h00);
        settle();
        xfer(0, `ASU_OFF_STATUS, 0);
        check("off status", rd, 32'h0B);
        check("off pins", {tx_oe, rx_in_sel, pullup_off}, 32'h0);
        xfer(0, `ASU_OFF_ENIRQ, 0);
        check("off enables", rd, 32'h24);
        xfer(1, `ASU_OFF_FRAME, 32'h80);
        xfer(0, `ASU_OFF_STATUS, 0);
        check("flushed", rd & 32'h04, 32'h0);
    endtask

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_enable();
        t_transmit();
        t_receive();
        t_overrun();
        t_disable();
        give_verdict();
    end

    initial begin
        repeat (40000) @(posedge hclk);
        n_fail++;
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
